/* File: core/caf_pkg.sv */
// Shared constants and types for the acceptance filter and error counter block.
// Assumes a 32-bit AHB-Lite register bus with one word per register.
package caf_pkg;
    // Printed register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL   = 8'h0b;
    localparam logic [7:0] IDX_MISC      = 8'h0d;
    localparam logic [7:0] IDX_RX_ERR    = 8'h0e;
    localparam logic [7:0] IDX_TX_ERR    = 8'h0f;
    localparam logic [7:0] IDX_PATTERN0  = 8'h10;
    localparam logic [7:0] IDX_MASK0     = 8'h18;
    localparam logic [7:0] ADDR_CONTROL  = 8'(IDX_CONTROL * 4);
    localparam logic [7:0] ADDR_MISC     = 8'(IDX_MISC * 4);
    localparam logic [7:0] ADDR_RX_ERR   = 8'(IDX_RX_ERR * 4);
    localparam logic [7:0] ADDR_TX_ERR   = 8'(IDX_TX_ERR * 4);
    localparam logic [2:0] ADDR_PAT_HI   = 3'h2;  // Byte address bits 7:5 for pattern bytes
    localparam logic [2:0] ADDR_MSK_HI   = 3'h3;  // Byte address bits 7:5 for mask bytes

    // Field positions
    localparam int ORG_LSB     = 4;
    localparam int HIT_LSB     = 0;
    localparam int BUSOFF_HOLD_FLAG_BIT  = 0;

    // Reset values
    localparam logic [7:0] PATTERN_RST = 8'h00;
    localparam logic [7:0] MASK_RST    = 8'h00;
    localparam logic [7:0] ERR_RST     = 8'h00;
    localparam logic [2:0] HIT_RST     = 3'h0;

    localparam int NUM_BYTES = 8;

    // Filter organization encodings
    typedef enum logic [1:0] {
        ORG_TWO_32   = 2'b00,
        ORG_FOUR_16  = 2'b01,
        ORG_EIGHT_8  = 2'b10,
        ORG_CLOSED   = 2'b11
    } caf_org_t;

    // One received frame's identifier as seen by the filter
    typedef struct packed {
        logic [3:0][7:0] identifierBytes;  // Byte 0 is the first on the wire
        logic            extended;
    } caf_frame_t;
endpackage

/* File: core/caf_accept_filter_errcnt.sv */
// Identifier acceptance filter, error counter views and bus-off hold flag.
// Assumes one clock; frame, counter and mode inputs come from logic on clk.
`timescale 1ns/1ns
`default_nettype none
module caf_accept_filter_errcnt
    import caf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        initRequest,
    input  wire logic        initAcknowledge,
    input  wire logic        busoffUserRecoveryMode,
    input  wire logic        busOff,
    input  wire logic [7:0]  receiveFaultTally,
    input  wire logic [7:0]  transmitFaultTally,
    input  wire logic        frameValid,
    input  wire caf_frame_t  frameIn,
    output logic             frameAccepted,
    output caf_frame_t       backgroundFrame,
    output caf_frame_t       foregroundFrame,
    output logic [2:0]       filterHitIndex,
    output logic             busoffHoldFlag,
    output logic             recoveryRequest
);

    // One byte of the filter: ones where the bit matches or is masked off
    function automatic logic byteMatch(input logic [7:0] id, input logic [7:0] pat, input logic [7:0] msk);
        byteMatch = &(~(id ^ pat) | msk);
    endfunction

    // Bus state
    logic        wrPend_r,   wrPend_nxt;
    logic        rdPend_r,   rdPend_nxt;
    logic        rdDone_r,   rdDone_nxt;
    logic [7:0]  addr_r,     addr_nxt;
    logic [31:0] rdata_r,    rdata_nxt;
    // Configuration and status
    logic [7:0]  pattern_r   [NUM_BYTES];
    logic [7:0]  pattern_nxt [NUM_BYTES];
    logic [7:0]  mask_r      [NUM_BYTES];
    logic [7:0]  mask_nxt    [NUM_BYTES];
    caf_org_t    org_r,      org_nxt;
    logic [2:0]  hit_r,      hit_nxt;
    logic [7:0]  receive_fault_tally_r,    receive_fault_tally_nxt;
    logic [7:0]  transmit_fault_tally_r,    transmit_fault_tally_nxt;
    logic        hold_r,     hold_nxt;
    logic        busOffPrev_r, busOffPrev_nxt;
    logic        recov_r,    recov_nxt;
    caf_frame_t  bg_r,       bg_nxt;
    caf_frame_t  fg_r,       fg_nxt;
    logic        accept_r,   accept_nxt;

    logic        addrPhase;
    logic        initMode;
    logic        holdW1c;
    logic [7:0]  hitVec;
    logic        anyHit;
    logic [2:0]  hitIdx;
    logic [31:0] readValue;

    // Read data is captured one cycle into the data phase, so a read always
    // sees the effect of a write that just finished; costs one wait state
    assign hreadyout = ~rdPend_r;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;
    assign addrPhase = hsel & htrans[1] & hready;
    assign initMode  = initRequest & initAcknowledge;
    assign holdW1c   = wrPend_r && addr_r == ADDR_MISC && hwdata[BUSOFF_HOLD_FLAG_BIT];

    assign frameAccepted   = accept_r;
    assign backgroundFrame = bg_r;
    assign foregroundFrame = fg_r;
    assign filterHitIndex  = hit_r;
    assign busoffHoldFlag  = hold_r;
    assign recoveryRequest = recov_r;

    // Per-filter match for the frame arriving now
    always_comb begin
        hitVec = 8'h00;
        case (org_r)
            ORG_TWO_32: begin
                for (int f = 0; f < 2; f++) begin
                    hitVec[f] = byteMatch(frameIn.identifierBytes[0], pattern_r[4*f], mask_r[4*f])
                              & byteMatch(frameIn.identifierBytes[1], pattern_r[4*f+1], mask_r[4*f+1])
                              & (~frameIn.extended
                                 | (byteMatch(frameIn.identifierBytes[2], pattern_r[4*f+2], mask_r[4*f+2])
                                    & byteMatch(frameIn.identifierBytes[3], pattern_r[4*f+3], mask_r[4*f+3])));
                end
            end
            ORG_FOUR_16: begin
                for (int f = 0; f < 4; f++) begin
                    hitVec[f] = byteMatch(frameIn.identifierBytes[0], pattern_r[2*f], mask_r[2*f])
                              & byteMatch(frameIn.identifierBytes[1], pattern_r[2*f+1], mask_r[2*f+1]);
                end
            end
            ORG_EIGHT_8: begin
                for (int f = 0; f < 8; f++) begin
                    hitVec[f] = byteMatch(frameIn.identifierBytes[0], pattern_r[f], mask_r[f]);
                end
            end
            default: hitVec = 8'h00;
        endcase
    end

    // Lowest numbered matching filter wins the hit index
    always_comb begin
        anyHit = |hitVec;
        hitIdx = 3'h0;
        for (int f = 7; f >= 0; f--) begin
            if (hitVec[f]) begin
                hitIdx = 3'(f);
            end
        end
    end

    // Register read mux; reserved bits read zero
    always_comb begin
        readValue = 32'h0000_0000;
        if (addr_r == ADDR_CONTROL) begin
            readValue[ORG_LSB +: 2] = org_r;
            readValue[HIT_LSB +: 3] = hit_r;
        end else if (addr_r == ADDR_MISC) begin
            readValue[BUSOFF_HOLD_FLAG_BIT] = hold_r;
        end else if (addr_r == ADDR_RX_ERR) begin
            readValue[7:0] = receive_fault_tally_r;
        end else if (addr_r == ADDR_TX_ERR) begin
            readValue[7:0] = transmit_fault_tally_r;
        end else if (addr_r[7:5] == ADDR_PAT_HI) begin
            readValue[7:0] = pattern_r[addr_r[4:2]];
        end else if (addr_r[7:5] == ADDR_MSK_HI) begin
            readValue[7:0] = mask_r[addr_r[4:2]];
        end
    end

    // Bus phase tracking
    always_comb begin
        wrPend_nxt = 1'b0;
        rdPend_nxt = 1'b0;
        rdDone_nxt = 1'b0;
        addr_nxt   = addr_r;
        rdata_nxt  = rdata_r;
        if (rdPend_r) begin
            rdata_nxt  = readValue;
            rdDone_nxt = 1'b1;
        end else if (addrPhase) begin
            addr_nxt   = haddr[7:0];
            wrPend_nxt = hwrite;
            rdPend_nxt = ~hwrite;
        end
    end

    // Configuration writes; filter bytes and layout only move in init mode
    always_comb begin
        pattern_nxt = pattern_r;
        mask_nxt    = mask_r;
        org_nxt     = org_r;
        if (wrPend_r && initMode) begin
            if (addr_r == ADDR_CONTROL) begin
                org_nxt = caf_org_t'(hwdata[ORG_LSB +: 2]);
            end else if (addr_r[7:5] == ADDR_PAT_HI) begin
                pattern_nxt[addr_r[4:2]] = hwdata[7:0];
            end else if (addr_r[7:5] == ADDR_MSK_HI) begin
                mask_nxt[addr_r[4:2]] = hwdata[7:0];
            end
        end
    end

    // Counter views track the error logic; no write path
    always_comb begin
        receive_fault_tally_nxt = receiveFaultTally;
        transmit_fault_tally_nxt = transmitFaultTally;
    end

    // Bus-off hold flag; a bus-off entry in the clearing cycle keeps it set
    always_comb begin
        busOffPrev_nxt = busOff;
        recov_nxt      = holdW1c & hold_r & busOff;
        hold_nxt       = hold_r;
        if (!busOff) begin
            hold_nxt = 1'b0;
        end else if (busoffUserRecoveryMode && !busOffPrev_r) begin
            hold_nxt = 1'b1;
        end else if (holdW1c) begin
            hold_nxt = 1'b0;
        end
    end

    // Background takes every frame; foreground only takes accepted ones
    always_comb begin
        bg_nxt     = bg_r;
        fg_nxt     = fg_r;
        hit_nxt    = hit_r;
        accept_nxt = 1'b0;
        if (frameValid) begin
            bg_nxt = frameIn;
            if (anyHit) begin
                fg_nxt     = frameIn;
                hit_nxt    = hitIdx;
                accept_nxt = 1'b1;
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPend_r     <= 1'b0;
            rdPend_r     <= 1'b0;
            rdDone_r     <= 1'b0;
            addr_r       <= 8'h00;
            rdata_r      <= 32'h0000_0000;
            for (int i = 0; i < NUM_BYTES; i++) begin
                pattern_r[i] <= PATTERN_RST;
                mask_r[i]    <= MASK_RST;
            end
            org_r        <= ORG_TWO_32;
            hit_r        <= HIT_RST;
            receive_fault_tally_r      <= ERR_RST;
            transmit_fault_tally_r      <= ERR_RST;
            hold_r       <= 1'b0;
            busOffPrev_r <= 1'b0;
            recov_r      <= 1'b0;
            bg_r         <= '0;
            fg_r         <= '0;
            accept_r     <= 1'b0;
        end else begin
            wrPend_r     <= wrPend_nxt;
            rdPend_r     <= rdPend_nxt;
            rdDone_r     <= rdDone_nxt;
            addr_r       <= addr_nxt;
            rdata_r      <= rdata_nxt;
            pattern_r    <= pattern_nxt;
            mask_r       <= mask_nxt;
            org_r        <= org_nxt;
            hit_r        <= hit_nxt;
            receive_fault_tally_r      <= receive_fault_tally_nxt;
            transmit_fault_tally_r      <= transmit_fault_tally_nxt;
            hold_r       <= hold_nxt;
            busOffPrev_r <= busOffPrev_nxt;
            recov_r      <= recov_nxt;
            bg_r         <= bg_nxt;
            fg_r         <= fg_nxt;
            accept_r     <= accept_nxt;
        end
    end

    // Flat copies of the filter bytes so one compare covers the whole array
    logic [NUM_BYTES*8-1:0] patFlat;
    logic [NUM_BYTES*8-1:0] mskFlat;
    for (genvar g = 0; g < NUM_BYTES; g++) begin : g_flat
        assign patFlat[8*g +: 8] = pattern_r[g];
        assign mskFlat[8*g +: 8] = mask_r[g];
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_hold_set_entry: assert property (
        busOff && !busOffPrev_r && busoffUserRecoveryMode |=> hold_r)
        else $error("hold flag not set on bus-off entry");
    chk_hold_stays: assert property (
        hold_r && busOff && !holdW1c |=> hold_r)
        else $error("hold flag dropped without request");
    chk_hold_not_busoff: assert property (
        !$past(busOff) |-> !hold_r)
        else $error("hold flag set while not bus-off");
    chk_w1c_recovery: assert property (
        hold_r && busOff && holdW1c |=> recov_r ##1 !recov_r)
        else $error("recovery request not one pulse");
    chk_w0_ignored: assert property (
        wrPend_r && addr_r == ADDR_MISC && !hwdata[BUSOFF_HOLD_FLAG_BIT] && hold_r && busOff |=> hold_r)
        else $error("write of zero cleared hold flag");
    chk_rx_count: assert property (
        rdDone_r && addr_r == ADDR_RX_ERR |-> hrdata == {24'h0, $past(receive_fault_tally_r)})
        else $error("receive count read mismatch");
    chk_tx_count: assert property (
        ##1 transmit_fault_tally_r == $past(transmitFaultTally))
        else $error("transmit count not tracking");
    chk_bg_store: assert property (
        frameValid |=> bg_r == $past(frameIn))
        else $error("frame not stored in background");
    chk_accept_cause: assert property (
        frameValid && !anyHit |=> !accept_r && fg_r == $past(fg_r))
        else $error("rejected frame reached foreground");
    chk_closed_none: assert property (
        org_r == ORG_CLOSED |-> !anyHit)
        else $error("closed filter matched");
    chk_init_write: assert property (
        wrPend_r && !initMode |=> patFlat == $past(patFlat) && mskFlat == $past(mskFlat) && org_r == $past(org_r))
        else $error("filter byte changed outside init");
    chk_hit_track: assert property (
        frameValid && anyHit |=> accept_r && hit_r == $past(hitIdx))
        else $error("hit index not updated");
    chk_read_wait: assert property (
        rdPend_r |-> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_ready: assert property (
        wrPend_r |-> hreadyout)
        else $error("write data phase stalled");

    // Hold flag and counter view checks
    chk_hold_cause: assert property (
        !hold_r && !(busOff && !busOffPrev_r && busoffUserRecoveryMode) |=> !hold_r)
        else $error("hold flag rose without bus-off entry");
    chk_w1c_clear: assert property (
        holdW1c && !(busoffUserRecoveryMode && busOff && !busOffPrev_r) |=> !hold_r)
        else $error("write of one left hold flag set");
    chk_recov_cause: assert property (
        recov_r |-> $past(holdW1c && hold_r && busOff))
        else $error("recovery request without clear");
    chk_hold_read: assert property (
        rdDone_r && addr_r == ADDR_MISC |-> hrdata == {31'h0, $past(hold_r)})
        else $error("hold flag read mismatch");
    chk_rx_track: assert property (
        ##1 receive_fault_tally_r == $past(receiveFaultTally))
        else $error("receive count not tracking");
    chk_tx_read: assert property (
        rdDone_r && addr_r == ADDR_TX_ERR |-> hrdata == {24'h0, $past(transmit_fault_tally_r)})
        else $error("transmit count read mismatch");

    // Frame path checks
    chk_accept_source: assert property (
        accept_r |-> $past(frameValid) && $past(anyHit))
        else $error("accept pulse without matching frame");
    chk_bg_keep: assert property (
        !frameValid |=> bg_r == $past(bg_r))
        else $error("background changed without frame");
    chk_hit_keep: assert property (
        !(frameValid && anyHit) |=> hit_r == $past(hit_r))
        else $error("hit index changed without accepted frame");
    chk_closed_keep: assert property (
        org_r == ORG_CLOSED && frameValid |=> !accept_r && fg_r == $past(fg_r))
        else $error("closed filter reloaded foreground");

    cov_accept_32: cover property (org_r == ORG_TWO_32 && frameValid && anyHit && frameIn.extended);
    cov_accept_8: cover property (org_r == ORG_EIGHT_8 && frameValid && hitIdx == 3'h7);
    cov_drop: cover property (frameValid && !anyHit);
    cov_closed_drop: cover property (org_r == ORG_CLOSED && frameValid);
    cov_recovery: cover property (hold_r ##[1:20] recov_r);

endmodule // caf_accept_filter_errcnt
`default_nettype wire

/* File: sim/caf_frame_source.sv */
// Behavioural model of the CAN nodes that hand received identifiers to the filter.
// Assumes the bench raises sendReq for one clk cycle per frame.
`timescale 1ns/1ns
`default_nettype none
module caf_frame_source
    import caf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       sendReq,
    input  wire caf_frame_t sendFrame,
    output logic            frameValid,
    output caf_frame_t      frameIn
);
    // One-cycle valid; between frames the bytes invert so a stale id never passes for a live one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frameValid <= 1'b0;
            frameIn    <= '0;
        end else begin
            frameValid <= sendReq;
            frameIn    <= sendReq ? sendFrame : ~frameIn;
        end
    end
endmodule // caf_frame_source
`default_nettype wire

/* File: sim/caf_accept_filter_errcnt_bench.sv */
// Self-checking bench for the acceptance filter, error counter views and hold flag.
// Assumes the frame source model and an AHB-Lite master made of tasks here.
`timescale 1ns/1ns
`default_nettype none
module caf_accept_filter_errcnt_bench;
    import caf_pkg::*;
    logic        clk, arst_n, hsel, hwrite, hreadyout, hresp, initReq, initAck, busoff_user_recovery_mode, busOff;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0]  rxTally, txTally;
    logic        sendReq, frameValid, frameAccepted, holdFlag, recReq;
    caf_frame_t  sendFrame, frameIn, bgFrame, fgFrame, fgExp;
    logic [2:0]  hitIdx, hitExp;
    int          num_errors, tests_run;
    logic [7:0]  pat [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'ha1, 8'hb2, 8'hc3, 8'hd4};
    logic [31:0] ids [4] = '{32'h0, 32'h0000_4433, 32'h0000_00c3, 32'hd4c3_b2a1};
    logic [2:0]  hits [4] = '{3'h0, 3'h1, 3'h6, 3'h0};

    caf_accept_filter_errcnt i_caf_accept_filter_errcnt (
        .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .initRequest(initReq), .initAcknowledge(initAck), .busoffUserRecoveryMode(busoff_user_recovery_mode),
        .busOff(busOff), .receiveFaultTally(rxTally), .transmitFaultTally(txTally),
        .frameValid(frameValid), .frameIn(frameIn), .frameAccepted(frameAccepted),
        .backgroundFrame(bgFrame), .foregroundFrame(fgFrame), .filterHitIndex(hitIdx),
        .busoffHoldFlag(holdFlag), .recoveryRequest(recReq));

    caf_frame_source i_caf_frame_source (
        .clk(clk), .arst_n(arst_n), .sendReq(sendReq), .sendFrame(sendFrame),
        .frameValid(frameValid), .frameIn(frameIn));

    // Counts every comparison and reports a mismatch at once
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (!ok) begin
            num_errors++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask

    // One AHB single transfer; holds each phase until hready is seen high at an edge
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp === 1'b0, "response not OKAY");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahb(a, 1'b1, d, unused);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] rd;
        ahb(a, 1'b0, 32'h0, rd);
        chk(rd === exp, msg);
    endtask

    // Sends one frame and judges background, foreground, hit and the accept pulse
    task automatic frame(input logic ext, input logic [31:0] id, input logic acc, input logic [2:0] hit);
        caf_frame_t f;
        f = {id, ext};
        sendReq <= 1'b1;
        sendFrame <= f;
        @(posedge clk);
        sendReq <= 1'b0;
        repeat (2) @(posedge clk);
        if (acc) begin
            fgExp = f;
            hitExp = hit;
        end
        chk(frameAccepted === acc && bgFrame === f && fgFrame === fgExp && hitIdx === hitExp, "frame outcome");
    endtask

    // Counter views: reset zero, live values, writes have no effect; an unmapped address reads zero
    task automatic testCounters();
        initReq <= 1'b1;
        initAck <= 1'b1;
        rdChk(8'h38, 32'h0, "rx count reset");
        rdChk(8'h3c, 32'h0, "tx count reset");
        rxTally <= 8'h5a;
        txTally <= 8'ha5;
        repeat (2) @(posedge clk);
        wr(8'h38, 32'hff);
        wr(8'h3c, 32'hff);
        rdChk(8'h38, 32'h5a, "rx count value");
        rdChk(8'h3c, 32'ha5, "tx count value");
        rdChk(8'h0c, 32'h0, "unmapped read");
    endtask

    // Filter programming in init mode, then every organization with awkward ids
    // Odd mask bytes free their low three bits so standard ids can pass
    task automatic testFilter();
        for (int i = 0; i < 8; i++) begin
            wr(8'(8'h40 + 4 * i), {24'h0, pat[i]});
            wr(8'(8'h60 + 4 * i), (i == 4) ? 32'h0f : (i[0] ? 32'h07 : 32'h00));
        end
        rdChk(8'h44, 32'h22, "pattern readback");
        frame(1'b0, 32'hffff_2211, 1'b1, 3'h0);
        frame(1'b1, 32'hd4c3_b2ae, 1'b1, 3'h1);
        frame(1'b1, 32'hd4c2_b2a1, 1'b0, 3'h0);
        for (int i = 1; i < 4; i++) begin
            wr(8'h2c, {26'h0, i[1:0], 4'h0});
            frame(1'b1, ids[i], i < 3, hits[i]);
        end
        rdChk(8'h2c, 32'h36, "organization and hit");
    endtask

    // Outside init mode, pattern and organization writes leave contents alone
    task automatic testLock();
        initReq <= 1'b0;
        initAck <= 1'b0;
        wr(8'h40, 32'hff);
        wr(8'h2c, 32'h10);
        rdChk(8'h40, 32'h11, "pattern locked");
        rdChk(8'h2c, 32'h36, "organization locked");
    endtask

    // Hold flag: needs the mode, survives a zero write, one write clears and requests recovery
    task automatic testHold();
        busOff <= 1'b1;
        repeat (2) @(posedge clk);
        chk(holdFlag === 1'b0, "hold set without mode");
        busOff <= 1'b0;
        busoff_user_recovery_mode <= 1'b1;
        repeat (2) @(posedge clk);
        busOff <= 1'b1;
        repeat (2) @(posedge clk);
        chk(holdFlag === 1'b1, "hold not set");
        rdChk(8'h34, 32'h1, "hold read");
        wr(8'h34, 32'h0);
        rdChk(8'h34, 32'h1, "hold after zero write");
        wr(8'h34, 32'h1);
        @(posedge clk);
        chk(holdFlag === 1'b0 && recReq === 1'b1, "clear and request");
        @(posedge clk);
        chk(holdFlag === 1'b0 && recReq === 1'b0, "request pulse length");
        busOff <= 1'b0;
        repeat (2) @(posedge clk);
        busOff <= 1'b1;
        repeat (2) @(posedge clk);
        chk(holdFlag === 1'b1, "hold not set again");
        busOff <= 1'b0;
        repeat (2) @(posedge clk);
        chk(holdFlag === 1'b0, "hold kept after bus-off end");
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Watchdog sized well beyond the roughly 120 cycles the tests need
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end

    // Main sequence: reset for three cycles, then the scenarios in order
    initial begin
        {arst_n, hsel, hwrite, initReq, initAck, busoff_user_recovery_mode, busOff, sendReq} = '0;
        {haddr, hwdata, htrans, rxTally, txTally} = '0;
        {sendFrame, fgExp, hitExp} = '0;
        num_errors = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        testCounters();
        testFilter();
        testLock();
        testHold();
        print_verdict();
    end
endmodule // caf_accept_filter_errcnt_bench
`default_nettype wire
